// file: rtl/csb_pkg.sv
//****************************************************************
//****************************************************************
package csb_pkg;
   localparam int          ADDR_W        = 22;
   localparam int          KEY_WORDS     = 8;
   localparam logic [21:0] FLASH_LO      = 22'h300000;
   localparam logic [21:0] FLASH_HI      = 22'h33ffff;
   localparam logic [21:0] PWD_LO        = 22'h33fff8;
   localparam logic [21:0] OTP_LO        = 22'h380400;
   localparam logic [21:0] OTP_HI        = 22'h3807ff;
   localparam logic [21:0] SRAM_BASE     = 22'h008000;
   localparam int          SRAM_BLK_SH   = 12;
   localparam logic [2:0]  SRAM_BLKS     = 3'h7;
   localparam logic [2:0]  SRAM_DMA_LO   = 3'h4;
   localparam logic [4:0]  PWD_WAIT      = 5'h10;
   localparam logic [3:0]  STRAP_RESET   = 4'hf;
   localparam logic [1:0]  SETTLE_CYC    = 2'h3;
   localparam logic [5:0]  GPIO_UART_RX  = 6'h1c;
   localparam logic [5:0]  GPIO_UART_TX  = 6'h1d;
   localparam logic [5:0]  GPIO_CAN_RX   = 6'h1e;
   localparam logic [5:0]  GPIO_CAN_TX   = 6'h1f;
   localparam logic [5:0]  GPIO_SPI_RX   = 6'h10;
   localparam logic [5:0]  GPIO_SPI_TX   = 6'h11;
   localparam logic [5:0]  GPIO_I2C_RX   = 6'h20;
   localparam logic [5:0]  GPIO_I2C_TX   = 6'h21;
   localparam logic [5:0]  GPIO_MSP_RX   = 6'h15;
   localparam logic [5:0]  GPIO_MSP_TX   = 6'h14;

   typedef enum logic [1:0] {
      SRC_CPU = 2'h0, SRC_DEBUG = 2'h1, SRC_DMA = 2'h2, SRC_LOADER = 2'h3
   } csb_src_type;
   typedef enum logic [1:0] {
      KIND_READ = 2'h0, KIND_WRITE = 2'h1, KIND_FETCH = 2'h2
   } csb_kind_type;
   typedef enum logic [3:0] {
      BT_FLASH, BT_UART, BT_SPI, BT_I2C, BT_CAN, BT_MSP, BT_XBUS16,
      BT_XBUS32, BT_OTP, BT_PAR_GPIO, BT_PAR_XBUS, BT_SRAM, BT_POLL
   } csb_boot_tgt_type;
   typedef enum logic [1:0] {
      ST_SETTLE = 2'b00, ST_SAMPLE = 2'b01, ST_HELD = 2'b11, ST_POLL = 2'b10
   } csb_strap_st_type;

   typedef struct packed {
      logic              valid;
      csb_src_type       src;
      csb_kind_type      kind;
      logic [21:0]       addr;
   } csb_acc_type;
   typedef struct packed {
      logic              valid;
      logic [2:0]        idx;
      logic [15:0]       data;
   } csb_word_type;
   typedef struct packed {
      logic              valid;
      logic [3:0]        code;
      csb_boot_tgt_type  target;
      logic              skip_cal;
      logic [5:0]        rx_gpio;
      logic [5:0]        tx_gpio;
   } csb_boot_type;
endpackage

// file: rtl/csb_gate.sv
`timescale 1ns/100ps
`default_nettype none
module csb_gate (
   input  wire logic               CLK_I,
   input  wire logic               RESET_I,
   input  wire csb_pkg::csb_acc_type  ACC_I,
   input  wire logic [4:0]         FLASH_WS_I,
   input  wire csb_pkg::csb_word_type KEY_WR_I,
   input  wire csb_pkg::csb_word_type PWD_RD_I,
   input  wire logic [3:0]         STRAP_I,
   input  wire logic               EMU_ATTACHED_I,
   input  wire logic               EMU_WAIT_RESET_I,
   input  wire logic               EMU_IN_CONTROL_I,
   output logic                    ACC_DONE_O,
   output logic                    ACC_BLOCK_O,
   output logic [4:0]              ACC_WAIT_O,
   output logic                    LOCKED_O,
   output logic                    EMU_OPEN_O,
   output logic                    EMU_TRIP_O,
   output logic                    CORE_HOLD_O,
   output csb_pkg::csb_boot_type   BOOT_O
);
   import csb_pkg::*;

   //*************************************************************
   // pin synchronisers
   //*************************************************************
   logic [6:0] sync1_ff;
   logic [6:0] sync2_ff;
   always_ff @(posedge CLK_I) begin
      sync1_ff <= {EMU_IN_CONTROL_I, EMU_WAIT_RESET_I, EMU_ATTACHED_I,
                   STRAP_I};
      sync2_ff <= sync1_ff;
   end
   wire logic [3:0] strap_s = sync2_ff[3:0];
   wire logic       attached_s = sync2_ff[4];
   wire logic       wir_s = sync2_ff[5];
   wire logic       ctrl_s = sync2_ff[6];

   //*************************************************************
   // key and password store
   //*************************************************************
   logic [15:0] key_ff [KEY_WORDS];
   logic [15:0] pwd_ff [KEY_WORDS];
   logic [7:0]  seen_ff;
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         seen_ff <= 8'h00;
         for (int i = 0; i < KEY_WORDS; i++) begin
            key_ff[i] <= 16'h0000;
            pwd_ff[i] <= 16'h0000;
         end
      end else begin
         if (KEY_WR_I.valid) begin
            key_ff[KEY_WR_I.idx] <= KEY_WR_I.data;
         end
         // dummy reads fill the compare copy
         if (PWD_RD_I.valid) begin
            pwd_ff[PWD_RD_I.idx] <= PWD_RD_I.data;
            seen_ff[PWD_RD_I.idx] <= 1'b1;
         end
      end
   end

   logic [127:0] key_v;
   logic [127:0] pwd_v;
   always_comb begin
      key_v = '0;
      pwd_v = '0;
      for (int i = 0; i < KEY_WORDS; i++) begin
         key_v[16*i +: 16] = key_ff[i];
         pwd_v[16*i +: 16] = pwd_ff[i];
      end
   end
   wire logic all_seen = &seen_ff;
   // an all-zero password can never be matched: permanent lock
   wire logic full_ok = all_seen && (key_v == pwd_v) && (|pwd_v);
   wire logic emu_ok  = all_seen &&
        ((key_v[63:0] == pwd_v[63:0]) || (&pwd_v[63:0]));

   logic locked_ff;
   logic emu_open_ff;
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         locked_ff   <= 1'b1;
         emu_open_ff <= 1'b0;
      end else begin
         locked_ff   <= ~full_ok;
         emu_open_ff <= emu_ok | full_ok;
      end
   end
   assign LOCKED_O = locked_ff;
   assign EMU_OPEN_O = emu_open_ff;

   //*************************************************************
   // access classification
   //*************************************************************
   wire logic [21:0] sram_off = ACC_I.addr - SRAM_BASE;
   wire logic in_sram  = (ACC_I.addr >= SRAM_BASE) &&
        (sram_off[21:SRAM_BLK_SH+3] == '0);
   wire logic [2:0] blk = sram_off[SRAM_BLK_SH +: 3];
   wire logic in_flash = (ACC_I.addr >= FLASH_LO) && (ACC_I.addr <= FLASH_HI);
   wire logic in_otp   = (ACC_I.addr >= OTP_LO) && (ACC_I.addr <= OTP_HI);
   wire logic in_pwd   = (ACC_I.addr >= PWD_LO) && (ACC_I.addr <= FLASH_HI);
   wire logic secure   = in_flash || in_otp ||
        (in_sram && blk < SRAM_DMA_LO);
   wire logic ext_bus  = !in_flash && !in_otp && !in_sram;

   logic block_c;
   always_comb begin
      block_c = 1'b0;
      if (locked_ff && secure && (ACC_I.src == SRC_DEBUG ||
                                  ACC_I.src == SRC_LOADER)) begin
         block_c = 1'b1;
      end
      if (locked_ff && ext_bus && ACC_I.kind == KIND_FETCH) begin
         block_c = 1'b1;
      end
      if (ACC_I.src == SRC_DMA && !(in_sram && blk >= SRAM_DMA_LO)) begin
         block_c = 1'b1;
      end
   end

   logic       done_ff;
   logic       block_ff;
   logic [4:0] wait_ff;
   logic       trip_ff;
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         done_ff  <= 1'b0;
         block_ff <= 1'b0;
         wait_ff  <= 5'h00;
      end else begin
         done_ff  <= ACC_I.valid;
         block_ff <= ACC_I.valid && block_c;
         // fixed wait count so the compare never depends on setup
         wait_ff  <= (ACC_I.valid && in_pwd) ? PWD_WAIT : FLASH_WS_I;
      end
   end

   // trip is sticky; only a device reset reconnects
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         trip_ff <= 1'b0;
      end else if (ACC_I.valid && secure && attached_s && !emu_open_ff &&
                   ACC_I.src != SRC_DMA) begin
         trip_ff <= 1'b1;
      end
   end
   assign ACC_DONE_O  = done_ff;
   assign ACC_BLOCK_O = block_ff;
   assign ACC_WAIT_O  = wait_ff;
   assign EMU_TRIP_O  = trip_ff;

   logic hold_ff;
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         hold_ff <= 1'b1;
      end else begin
         hold_ff <= wir_s && !ctrl_s;
      end
   end
   assign CORE_HOLD_O = hold_ff;

   //*************************************************************
   // boot strap decode
   //*************************************************************
   function automatic csb_boot_type decode(input logic [3:0] c);
      csb_boot_type b;
      b = '0;
      b.valid = 1'b1;
      b.code = c;
      unique case (c)
         4'hf: b.target = BT_FLASH;
         4'he: begin
            b.target = BT_UART;
            b.rx_gpio = GPIO_UART_RX;
            b.tx_gpio = GPIO_UART_TX;
         end
         4'hd: begin
            b.target = BT_SPI;
            b.rx_gpio = GPIO_SPI_RX;
            b.tx_gpio = GPIO_SPI_TX;
         end
         4'hc: begin
            b.target = BT_I2C;
            b.rx_gpio = GPIO_I2C_RX;
            b.tx_gpio = GPIO_I2C_TX;
         end
         4'hb: begin
            b.target = BT_CAN;
            b.rx_gpio = GPIO_CAN_RX;
            b.tx_gpio = GPIO_CAN_TX;
         end
         4'ha: begin
            b.target = BT_MSP;
            b.rx_gpio = GPIO_MSP_RX;
            b.tx_gpio = GPIO_MSP_TX;
         end
         4'h9: b.target = BT_XBUS16;
         4'h8: b.target = BT_XBUS32;
         4'h7: b.target = BT_OTP;
         4'h6: b.target = BT_PAR_GPIO;
         4'h5: b.target = BT_PAR_XBUS;
         4'h4: b.target = BT_SRAM;
         4'h3: b.target = BT_POLL;
         4'h2: begin
            b.target = BT_FLASH;
            b.skip_cal = 1'b1;
         end
         4'h1: begin
            b.target = BT_SRAM;
            b.skip_cal = 1'b1;
         end
         4'h0: begin
            b.target = BT_UART;
            b.skip_cal = 1'b1;
            b.rx_gpio = GPIO_UART_RX;
            b.tx_gpio = GPIO_UART_TX;
         end
      endcase
      return b;
   endfunction

   // wait for the synchroniser to fill before trusting the straps
   csb_strap_st_type st_ff;
   logic [1:0]       settle_ff;
   csb_boot_type     boot_ff;
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         st_ff     <= ST_SETTLE;
         settle_ff <= 2'h0;
         boot_ff   <= '0;
      end else begin
         unique case (st_ff)
            ST_SETTLE: begin
               settle_ff <= settle_ff + 2'h1;
               if (settle_ff == SETTLE_CYC) begin
                  st_ff <= ST_SAMPLE;
               end
            end
            ST_SAMPLE, ST_POLL: begin
               boot_ff <= decode(strap_s);
               st_ff   <= (strap_s == 4'h3) ? ST_POLL : ST_HELD;
            end
            ST_HELD: st_ff <= ST_HELD;
         endcase
      end
   end
   assign BOOT_O = boot_ff;

   //*************************************************************
   // checks
   //*************************************************************
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   a_reset_locks: assert property ($past(RESET_I) |-> LOCKED_O)
      else $error("gate not locked after reset");
   a_full_unlock: assert property (full_ok |=> !LOCKED_O)
      else $error("full key match did not unlock");
   a_debug_block: assert property (ACC_I.valid && ACC_I.src == SRC_DEBUG
      && secure && LOCKED_O |=> ACC_BLOCK_O && ACC_DONE_O)
      else $error("debug read of secure memory passed");
   a_open_sram: assert property (ACC_I.valid && in_sram && blk >= 3'h4
      |=> !ACC_BLOCK_O)
      else $error("upper sram block refused");
   a_dma_low: assert property (ACC_I.valid && ACC_I.src == SRC_DMA
      && in_sram && blk < 3'h4 |=> ACC_BLOCK_O)
      else $error("dma reached low sram block");
   a_emu_trip: assert property (ACC_I.valid && secure && attached_s
      && !EMU_OPEN_O && ACC_I.src == SRC_CPU |=> EMU_TRIP_O [*2])
      else $error("secure access did not trip emulation");
   a_ones_open: assert property (all_seen && (&pwd_v[63:0])
      |=> EMU_OPEN_O)
      else $error("unprogrammed password did not open emulation");
   a_pwd_wait: assert property (ACC_I.valid && in_pwd
      |=> ACC_WAIT_O == 5'h10)
      else $error("password read wait count wrong");
   a_core_hold: assert property (wir_s && !ctrl_s |=> CORE_HOLD_O)
      else $error("core not held in wait-in-reset");
   a_boot_held: assert property (st_ff == ST_HELD |=> $stable(BOOT_O))
      else $error("held boot code changed");
   a_strap_open: assert property (BOOT_O.valid && BOOT_O.code == 4'hf
      |-> BOOT_O.target == BT_FLASH && !BOOT_O.skip_cal)
      else $error("open straps not decoded to flash");

   c_unlock: cover property ($fell(LOCKED_O));
   c_trip: cover property ($rose(EMU_TRIP_O));
   c_poll_exit: cover property (st_ff == ST_POLL ##1 st_ff == ST_HELD);
endmodule
`default_nettype wire

// file: verif/csb_emu_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// emulator pod and boot strap pins
// ****************************************
module csb_emu_model (
   input  wire logic       clk_i,
   output logic [3:0]      strap_o,
   output logic            attached_o,
   output logic            wait_rst_o,
   output logic            in_ctrl_o
);
   logic [3:0] drv_q;
   logic [3:0] drv_en;
   // pins left undriven float high on their pull-ups
   assign strap_o = (drv_q & drv_en) | ~drv_en;
   initial begin
      drv_q = 4'h0;
      drv_en = 4'h0;
      attached_o = 1'b0;
      wait_rst_o = 1'b0;
      in_ctrl_o = 1'b0;
   end
   // leaving the poll loop means rewiring the straps
   task automatic straps(input logic [3:0] en, input logic [3:0] v);
      @(posedge clk_i);
      #1;
      drv_en = en;
      drv_q = v;
   endtask
   // pod may hold the core until it owns it
   task automatic emu(input logic att, input logic wr, input logic ctl);
      @(posedge clk_i);
      #1;
      attached_o = att;
      wait_rst_o = wr;
      in_ctrl_o = ctl;
   endtask
endmodule
`default_nettype wire

// file: verif/tb_code_security_and_boot_select.sv
`timescale 1ns/100ps
`default_nettype none
module tb_code_security_and_boot_select;
   import csb_pkg::*;
   logic             clk;
   logic             rst;
   csb_acc_type      acc;
   logic [4:0]       ws;
   csb_word_type     key_wr;
   csb_word_type     pwd_rd;
   logic [3:0]       strap;
   logic             att;
   logic             wrst;
   logic             ctl;
   logic             done;
   logic             blk;
   logic [4:0]       wt;
   logic             lock;
   logic             eopen;
   logic             trip;
   logic             hold;
   csb_boot_type     boot;
   int               failures;
   int               cmp_count;
   localparam logic [127:0] P = 128'h0123456789abcdef_fedcba9876543210;
   localparam csb_boot_tgt_type TGT[16] = '{BT_UART, BT_SRAM, BT_FLASH,
      BT_POLL, BT_SRAM, BT_PAR_XBUS, BT_PAR_GPIO, BT_OTP, BT_XBUS32,
      BT_XBUS16, BT_MSP, BT_CAN, BT_I2C, BT_SPI, BT_UART, BT_FLASH};

   csb_gate u_dut (.CLK_I(clk), .RESET_I(rst), .ACC_I(acc),
      .FLASH_WS_I(ws), .KEY_WR_I(key_wr), .PWD_RD_I(pwd_rd),
      .STRAP_I(strap), .EMU_ATTACHED_I(att), .EMU_WAIT_RESET_I(wrst),
      .EMU_IN_CONTROL_I(ctl), .ACC_DONE_O(done), .ACC_BLOCK_O(blk),
      .ACC_WAIT_O(wt), .LOCKED_O(lock), .EMU_OPEN_O(eopen),
      .EMU_TRIP_O(trip), .CORE_HOLD_O(hold), .BOOT_O(boot));
   csb_emu_model u_emu (.clk_i(clk), .strap_o(strap), .attached_o(att),
      .wait_rst_o(wrst), .in_ctrl_o(ctl));

   always #2 clk = ~clk;

   // ****************************************
   // shared helpers
   // ****************************************
   task automatic check(input string nm, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic close_out();
      if (failures == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset();
      rst = 1'b1;
      tick(5);
      rst = 1'b0;
   endtask
   // a missing boot result after 20 cycles ends the run as a fail, not a silent pass
   task automatic wait_boot();
      int i;
      for (i = 0; i < 20 && boot.valid !== 1'b1; i++) tick(1);
      if (i == 20) begin
         failures++;
         close_out();
      end
   endtask
   task automatic acc_chk(input csb_src_type s, input csb_kind_type k,
                          input logic [21:0] a, input logic b,
                          input logic [4:0] w);
      acc = '{1'b1, s, k, a};
      tick(1);
      check("done", 32'(done), 32'h1);
      check("block", 32'(blk), 32'(b));
      check("wait", 32'(wt), 32'(w));
      // valid drops a cycle apart so back-to-back calls never re-drive it
      acc.valid = 1'b0;
      tick(1);
      check("done_end", 32'(done), 32'h0);
      check("block_end", 32'(blk), 32'h0);
   endtask
   task automatic unlock(input logic [127:0] pw, key, input logic [7:0] m);
      for (int i = 0; i < 8; i++) begin
         pwd_rd = '{m[i], 3'(i), pw[16*i+:16]};
         key_wr = '{1'b1, 3'(i), key[16*i+:16]};
         tick(1);
      end
      pwd_rd.valid = 1'b0;
      key_wr.valid = 1'b0;
      tick(3);
   endtask
   task automatic lk(input logic [127:0] pw, key, input logic [7:0] m,
                     input logic el, eo);
      do_reset();
      unlock(pw, key, m);
      check("locked", 32'(lock), 32'(el));
      check("emu_open", 32'(eopen), 32'(eo));
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_boot_table();
      logic [11:0] pins;
      for (int c = 0; c < 16; c++) begin
         u_emu.straps(4'hf, 4'(c));
         do_reset();
         wait_boot();
         check("code", 32'(boot.code), 32'(c));
         check("target", 32'(boot.target), 32'(TGT[c]));
         check("skip_cal", 32'(boot.skip_cal), 32'(c < 3));
         pins = {boot.rx_gpio, boot.tx_gpio};
         if (c == 14) check("uart", 32'(pins), 32'h71d);
         if (c == 11) check("can", 32'(pins), 32'h79f);
         if (c == 13) check("spi", 32'(pins), 32'h411);
         if (c == 12) check("i2c", 32'(pins), 32'h821);
         if (c == 10) check("msp", 32'(pins), 32'h554);
         if (c == 15) check("no_pins", 32'(pins), 32'h0);
      end
   endtask
   task automatic t_poll();
      u_emu.straps(4'hf, 4'h3);
      do_reset();
      wait_boot();
      check("poll", 32'(boot.target), 32'(BT_POLL));
      u_emu.straps(4'hf, 4'h5);
      tick(8);
      check("poll_exit", 32'(boot.target), 32'(BT_PAR_XBUS));
      u_emu.straps(4'hf, 4'h7);
      tick(8);
      check("held", 32'(boot.target), 32'(BT_PAR_XBUS));
   endtask
   task automatic t_access();
      do_reset();
      acc_chk(SRC_DEBUG, KIND_READ, 22'h300000, 1'b1, 5'h03);
      acc_chk(SRC_DEBUG, KIND_READ, 22'h33fffa, 1'b1, 5'h10);
      acc_chk(SRC_CPU, KIND_READ, 22'h33fff8, 1'b0, 5'h10);
      acc_chk(SRC_CPU, KIND_READ, 22'h33fff7, 1'b0, 5'h03);
      acc_chk(SRC_CPU, KIND_READ, 22'h33fff0, 1'b0, 5'h03);
      // password wait count must ignore the software setting
      ws = 5'h07;
      acc_chk(SRC_CPU, KIND_READ, 22'h33ffff, 1'b0, 5'h10);
      acc_chk(SRC_CPU, KIND_READ, 22'h300000, 1'b0, 5'h07);
      ws = 5'h03;
      acc_chk(SRC_LOADER, KIND_READ, 22'h380400, 1'b1, 5'h03);
      acc_chk(SRC_DEBUG, KIND_READ, 22'h00bfff, 1'b1, 5'h03);
      acc_chk(SRC_DEBUG, KIND_READ, 22'h00c000, 1'b0, 5'h03);
      acc_chk(SRC_CPU, KIND_FETCH, 22'h200000, 1'b1, 5'h03);
      acc_chk(SRC_DMA, KIND_READ, 22'h00c000, 1'b0, 5'h03);
      acc_chk(SRC_DMA, KIND_WRITE, 22'h00b000, 1'b1, 5'h03);
      check("no_trip", 32'(trip), 32'h0);
   endtask
   task automatic t_trip();
      do_reset();
      u_emu.emu(1'b1, 1'b0, 1'b0);
      tick(4);
      acc_chk(SRC_DMA, KIND_READ, 22'h00b000, 1'b1, 5'h03);
      tick(1);
      check("dma_trip", 32'(trip), 32'h0);
      acc_chk(SRC_CPU, KIND_READ, 22'h009000, 1'b0, 5'h03);
      tick(1);
      check("trip", 32'(trip), 32'h1);
      acc_chk(SRC_CPU, KIND_READ, 22'h200000, 1'b0, 5'h03);
      check("sticky", 32'(trip), 32'h1);
      u_emu.emu(1'b0, 1'b0, 1'b0);
      do_reset();
      check("trip_rst", 32'(trip), 32'h0);
   endtask
   task automatic t_hold();
      tick(4);
      check("run", 32'(hold), 32'h0);
      u_emu.emu(1'b1, 1'b1, 1'b0);
      tick(5);
      check("hold", 32'(hold), 32'h1);
      u_emu.emu(1'b1, 1'b1, 1'b1);
      tick(5);
      check("release", 32'(hold), 32'h0);
      u_emu.emu(1'b0, 1'b0, 1'b0);
   endtask
   task automatic t_unlock();
      lk(P, P, 8'hff, 1'b0, 1'b1);
      acc_chk(SRC_DEBUG, KIND_READ, 22'h300000, 1'b0, 5'h03);
      do_reset();
      check("relock", 32'(lock), 32'h1);
      lk(P, {~P[127:64], P[63:0]}, 8'hff, 1'b1, 1'b1);
      // emulation open: no trip, but reads stay refused
      u_emu.emu(1'b1, 1'b0, 1'b0);
      tick(3);
      acc_chk(SRC_DEBUG, KIND_READ, 22'h300000, 1'b1, 5'h03);
      check("open_no_trip", 32'(trip), 32'h0);
      u_emu.emu(1'b0, 1'b0, 1'b0);
      lk(P, {P[127:1], ~P[0]}, 8'hff, 1'b1, 1'b0);
      lk({P[127:64], {64{1'b1}}}, '0, 8'hff, 1'b1, 1'b1);
      lk(P, P, 8'h7f, 1'b1, 1'b0);
      do_reset();
      unlock('0, '0, 8'hff);
      check("zero_pwd", 32'(lock), 32'h1);
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      acc = '0;
      ws = 5'h03;
      key_wr = '0;
      pwd_rd = '0;
      failures = 0;
      cmp_count = 0;
      do_reset();
      check("locked0", 32'(lock), 32'h1);
      check("open0", 32'(eopen), 32'h0);
      wait_boot();
      check("open_pins", 32'(boot.code), 32'hf);
      t_hold();
      t_boot_table();
      t_poll();
      t_access();
      t_trip();
      t_unlock();
      close_out();
   end
endmodule
`default_nettype wire
